// ===== verilog/clk_out_cfg_defs.vh
/*
  Constants for the fractional clock output channel configuration bank:
  register indices, field positions, codes and reset values.
  Assumes inclusion by bare name from the bank module.
*/
`ifndef CLK_OUT_CFG_DEFS_VH
`define CLK_OUT_CFG_DEFS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_CH4_OUTPUT_CONFIG  5'h09
`define IDX_CH4_DIVIDER_HIGH   5'h0a
`define IDX_CH4_FRACTION_LOW   5'h0b
`define IDX_CH5_OUTPUT_CONFIG  5'h0c
`define IDX_CH5_DIVIDER_HIGH   5'h0d
`define IDX_CH5_FRACTION_LOW   5'h0e

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define CFG_SRC_HI       14
`define CFG_SRC_LO       13
`define CFG_PRE_HI       12
`define CFG_PRE_LO       10
`define CFG_FRAC_EN      9
`define CFG_SLEW         8
`define CFG_NEG_EN       7
`define CFG_POS_EN       6
`define CFG_DRV_HI       4
`define CFG_DRV_LO       3
`define CFG_CTL_HI       2
`define CFG_CTL_LO       1
`define CFG_SUPPLY       0
`define CFG_WMASK        16'h7fdf

// ----------------------------------------
// Divider register fields
// ----------------------------------------
`define DIV_INT_HI       11
`define DIV_INT_LO       4
`define DIV_FRAC_HI      3
`define DIV_FRAC_LO      0
`define DIV_WMASK        16'h0fff

// ----------------------------------------
// Codes
// ----------------------------------------
`define SRC_PLL          2'h0
`define SRC_PRIMARY      2'h1
`define SRC_SECONDARY    2'h2
`define PRE_DIV2         3'h0
`define PRE_DIV3         3'h1
`define PRE_DIV1         3'h7
`define DRV_LVDS         2'h0
`define DRV_LVCMOS       2'h1
`define DRV_HCSL         2'h2
`define CTL_OFF          2'h0
`define CTL_CLOCK        2'h1
`define CTL_LOW          2'h2
`define CTL_HIGH         2'h3

// Raw field codes and decoded ratios
`define SRC_CODE_PRIMARY   2'h1
`define SRC_CODE_SECONDARY 2'h2
`define DRV_CODE_LVCMOS    2'h2
`define DRV_CODE_HCSL      2'h3
`define RATIO_1            2'h1
`define RATIO_2            2'h2
`define RATIO_3            2'h3
`define RATIO_OFFSET       9'h001

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_REG          16'h0000
`define RST_RATIO        9'h001
`define RST_FLAG         1'b0

`endif

// ===== verilog/clock_output_channel_config.v
/*
  Register bank for fractional clock output channels 4 and 5: storage of
  six 16-bit registers and decode of each field into steering outputs.
  Decoded fields that need logic are held in flops loaded from the next
  register word, so they change on the same edge as the stored word.
  Fields that map one to one are driven straight from the stored word.
  Assumes a serial interface front end that presents word writes and reads
  on the same clock, one request per cycle; read data is registered and
  answers one cycle after the read strobe.
  Reserved bits are dropped on write, so they always read back as zero.
*/
`timescale 1ns/1ps
`include "clk_out_cfg_defs.vh"

module clock_output_channel_config (
  input  wire        clock_i,           // 20 MHz system clock
  input  wire        rst_i,             // Asynchronous reset, active high
  input  wire        wr_en_i,           // Register write strobe
  input  wire        rd_en_i,           // Register read strobe
  input  wire [4:0]  addr_i,            // Register index
  input  wire [15:0] wdata_i,           // Write data
  output reg  [15:0] rdata_o,           // Read data, valid cycle after rd_en_i
  output reg         rvalid_o,          // Read data valid pulse
  output wire [3:0]  ch_source_o,       // {ch5,ch4} source: 0 PLL, 1 primary, 2 secondary
  output wire [3:0]  ch_prescale_o,     // {ch5,ch4} effective prescale ratio 1..3
  output wire [1:0]  ch_fraction_en_o,  // {ch5,ch4} fractional divider enable
  output wire [1:0]  ch_edge_slow_o,    // {ch5,ch4} slow LVCMOS slew
  output wire [1:0]  ch_pos_en_o,       // {ch5,ch4} positive side enable
  output wire [1:0]  ch_neg_en_o,       // {ch5,ch4} negative side enable, gated
  output wire [3:0]  ch_driver_o,       // {ch5,ch4} 0 LVDS, 1 LVCMOS, 2 HCSL
  output wire [3:0]  ch_control_o,      // {ch5,ch4} 0 off, 1 clock, 2 low, 3 high
  output wire [1:0]  ch_supply_hi_o,    // {ch5,ch4} 1 for 2.5/3.3 V range
  output wire [17:0] ch_int_ratio_o,    // {ch5,ch4} 9-bit effective integer ratio
  output wire [39:0] ch_fraction_o      // {ch5,ch4} 20-bit fraction value
);

  parameter NCH = 2;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [15:0] cfg_q  [0:NCH-1];
  reg [15:0] div_q  [0:NCH-1];
  reg [15:0] frac_q [0:NCH-1];
  reg [15:0] cfg_d  [0:NCH-1];
  reg [15:0] div_d  [0:NCH-1];
  reg [15:0] frac_d [0:NCH-1];
  reg [15:0] rdata_d;

  // ----------------------------------------
  // Write path
  // ----------------------------------------
  // Next register words; reserved bits are masked so they always read zero
  always @* begin
    cfg_d[0]  = cfg_q[0];
    cfg_d[1]  = cfg_q[1];
    div_d[0]  = div_q[0];
    div_d[1]  = div_q[1];
    frac_d[0] = frac_q[0];
    frac_d[1] = frac_q[1];
    if (wr_en_i) begin
      case (addr_i)
        `IDX_CH4_OUTPUT_CONFIG: cfg_d[0]  = wdata_i & `CFG_WMASK;
        `IDX_CH4_DIVIDER_HIGH:  div_d[0]  = wdata_i & `DIV_WMASK;
        `IDX_CH4_FRACTION_LOW:  frac_d[0] = wdata_i;
        `IDX_CH5_OUTPUT_CONFIG: cfg_d[1]  = wdata_i & `CFG_WMASK;
        `IDX_CH5_DIVIDER_HIGH:  div_d[1]  = wdata_i & `DIV_WMASK;
        `IDX_CH5_FRACTION_LOW:  frac_d[1] = wdata_i;
        default: ;
      endcase
    end
  end

  // Storage; writes to unmapped indices leave every word unchanged
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q[0]  <= `RST_REG;
      cfg_q[1]  <= `RST_REG;
      div_q[0]  <= `RST_REG;
      div_q[1]  <= `RST_REG;
      frac_q[0] <= `RST_REG;
      frac_q[1] <= `RST_REG;
    end else begin
      cfg_q[0]  <= cfg_d[0];
      cfg_q[1]  <= cfg_d[1];
      div_q[0]  <= div_d[0];
      div_q[1]  <= div_d[1];
      frac_q[0] <= frac_d[0];
      frac_q[1] <= frac_d[1];
    end
  end

  // Read decode; unmapped indices read zero
  always @* begin
    case (addr_i)
      `IDX_CH4_OUTPUT_CONFIG: rdata_d = cfg_q[0];
      `IDX_CH4_DIVIDER_HIGH:  rdata_d = div_q[0];
      `IDX_CH4_FRACTION_LOW:  rdata_d = frac_q[0];
      `IDX_CH5_OUTPUT_CONFIG: rdata_d = cfg_q[1];
      `IDX_CH5_DIVIDER_HIGH:  rdata_d = div_q[1];
      `IDX_CH5_FRACTION_LOW:  rdata_d = frac_q[1];
      default:                rdata_d = `RST_REG;
    endcase
  end

  // Registered read answer
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o  <= `RST_REG;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o  <= rd_en_i ? rdata_d : rdata_o;
      rvalid_o <= rd_en_i;
    end
  end

  // ----------------------------------------
  // Field decode, one copy per channel
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      // Fields of the next register words
      wire [1:0] src_code = cfg_d[g][`CFG_SRC_HI:`CFG_SRC_LO];
      wire [2:0] pre_code = cfg_d[g][`CFG_PRE_HI:`CFG_PRE_LO];
      wire [1:0] drv_code = cfg_d[g][`CFG_DRV_HI:`CFG_DRV_LO];
      wire       frac_en  = cfg_d[g][`CFG_FRAC_EN];
      // Negative side only follows when the positive side is on
      wire       neg_d    = cfg_d[g][`CFG_NEG_EN] & cfg_d[g][`CFG_POS_EN];
      // Ratio is stored value plus one, widened to 9 bits
      wire [8:0] ratio_d  = {1'b0, div_d[g][`DIV_INT_HI:`DIV_INT_LO]} + `RATIO_OFFSET;
      reg  [1:0] src_d;
      reg  [1:0] pre_d;
      reg  [1:0] drv_d;
      // Decoded fields, held in flops
      reg  [1:0] src_q;
      reg  [1:0] pre_q;
      reg  [1:0] drv_q;
      reg        neg_q;
      reg  [8:0] ratio_q;

      // Source mux: 00 and 11 both fall back to the PLL
      always @* begin
        case (src_code)
          `SRC_CODE_PRIMARY:   src_d = `SRC_PRIMARY;
          `SRC_CODE_SECONDARY: src_d = `SRC_SECONDARY;
          default:             src_d = `SRC_PLL;
        endcase
      end

      // Prescale ratio; bypassed (ratio 1) with fraction off
      always @* begin
        if (!frac_en) begin
          pre_d = `RATIO_1;
        end else begin
          case (pre_code)
            `PRE_DIV2: pre_d = `RATIO_2;
            `PRE_DIV3: pre_d = `RATIO_3;
            `PRE_DIV1: pre_d = `RATIO_1;
            default:   pre_d = `RATIO_1;
          endcase
        end
      end

      // Driver type: 00 and 01 both LVDS
      always @* begin
        case (drv_code)
          `DRV_CODE_LVCMOS: drv_d = `DRV_LVCMOS;
          `DRV_CODE_HCSL:   drv_d = `DRV_HCSL;
          default:          drv_d = `DRV_LVDS;
        endcase
      end

      // Decoded fields load on the same edge as the stored word
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          src_q   <= `SRC_PLL;
          pre_q   <= `RATIO_1;
          drv_q   <= `DRV_LVDS;
          neg_q   <= `RST_FLAG;
          ratio_q <= `RST_RATIO;
        end else begin
          src_q   <= src_d;
          pre_q   <= pre_d;
          drv_q   <= drv_d;
          neg_q   <= neg_d;
          ratio_q <= ratio_d;
        end
      end

      // Decoded outputs straight from their flops
      assign ch_source_o[2*g+1:2*g]    = src_q;
      assign ch_prescale_o[2*g+1:2*g]  = pre_q;
      assign ch_driver_o[2*g+1:2*g]    = drv_q;
      // Gated negative side; the stored bit is kept as written
      assign ch_neg_en_o[g]            = neg_q;
      assign ch_int_ratio_o[9*g+8:9*g] = ratio_q;

      // Plain fields straight from the stored word
      assign ch_fraction_en_o[g]       = cfg_q[g][`CFG_FRAC_EN];
      assign ch_edge_slow_o[g]         = cfg_q[g][`CFG_SLEW];
      assign ch_pos_en_o[g]            = cfg_q[g][`CFG_POS_EN];
      assign ch_control_o[2*g+1:2*g]   = cfg_q[g][`CFG_CTL_HI:`CFG_CTL_LO];
      // Supply range takes effect when written; reset leaves 1.8 V setting
      assign ch_supply_hi_o[g]         = cfg_q[g][`CFG_SUPPLY];
      // Fraction upper bits come from the divider word, lower bits from the word after it
      assign ch_fraction_o[20*g+19:20*g] = {div_q[g][`DIV_FRAC_HI:`DIV_FRAC_LO], frac_q[g]};
    end
  endgenerate

endmodule

// ===== verif/cfg_host_model.sv
/* Host model: single-cycle register writes and reads into the bank.
   Assumes the bank answers a read one cycle after its strobe. */
`timescale 1ns/1ps
module cfg_host_model (
  input  wire        clock_i,            // Bank clock
  input  wire [15:0] rdata_i,            // Read data
  input  wire        rvalid_i,           // Read valid
  output reg         wr_en_o = 1'b0,     // Write strobe
  output reg         rd_en_o = 1'b0,     // Read strobe
  output reg  [4:0]  addr_o = 5'h00,     // Register index
  output reg  [15:0] wdata_o = 16'h0000  // Write data
);
  integer idle = 0;  // Extra idle cycles before a request
  // Write pulse; data scrambled once released
  task wr(input [4:0] a, input [15:0] d);
    begin
      repeat (idle) @(posedge clock_i);
      @(posedge clock_i) #1;
      wr_en_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(posedge clock_i) #1;
      wr_en_o = 1'b0;
      wdata_o = ~d;
    end
  endtask
  // Read pulse; answer taken after the next edge
  task rd(input [4:0] a, output [15:0] d);
    begin
      repeat (idle) @(posedge clock_i);
      @(posedge clock_i) #1;
      rd_en_o = 1'b1;
      addr_o = a;
      @(posedge clock_i) #1;
      rd_en_o = 1'b0;
      addr_o = ~a;
      d = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
    end
  endtask
endmodule

// ===== verif/clock_output_channel_config_chk.sv
/* Port assertions for the channel 4/5 bank.
   Assumes binding to the bank top module. */
`timescale 1ns/1ps
module clock_output_channel_config_chk (
  input wire        clock_i, rst_i, wr_en_i, rd_en_i, rvalid_o,  // Control
  input wire [4:0]  addr_i,                                      // Index
  input wire [15:0] wdata_i,                                     // Write data
  input wire [1:0]  ch_pos_en_o, ch_neg_en_o,                    // Sides
  input wire [3:0]  ch_source_o, ch_prescale_o, ch_driver_o, ch_control_o,  // Decodes
  input wire [17:0] ch_int_ratio_o,                              // Ratios
  input wire [39:0] ch_fraction_o                                // Fractions
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Expected decodes of the word on the write bus
  wire       w4 = wr_en_i && addr_i == 5'h09;
  wire       w5 = wr_en_i && addr_i == 5'h0c;
  wire [1:0] src = (wdata_i[14:13] == 2'h3) ? 2'h0 : wdata_i[14:13];
  wire [1:0] pre = !wdata_i[9] ? 2'h1 : (wdata_i[12:10] == 3'h0) ? 2'h2 : (wdata_i[12:10] == 3'h1) ? 2'h3 : 2'h1;
  wire [1:0] drv = wdata_i[4] ? wdata_i[4:3] - 2'h1 : 2'h0;
  a_src_ch4: assert property (w4 |=> ch_source_o[1:0] == $past(src)) else $error("ch4 source");
  a_layout_ch5: assert property (w5 |=> {ch_source_o[3:2], ch_prescale_o[3:2], ch_driver_o[3:2]} == $past({src, pre, drv})) else $error("ch5 layout");
  a_prescale_ch4: assert property (w4 |=> ch_prescale_o[1:0] == $past(pre)) else $error("ch4 prescale");
  a_neg_gated: assert property (w4 |=> ch_neg_en_o[0] == $past(wdata_i[7] & wdata_i[6])) else $error("neg side");
  a_driver_ch4: assert property (w4 |=> ch_driver_o[1:0] == $past(drv)) else $error("ch4 driver");
  a_control_ch4: assert property (w4 |=> ch_control_o[1:0] == $past(wdata_i[2:1])) else $error("ch4 control");
  a_ratio_ch4: assert property (wr_en_i && addr_i == 5'h0a |=> ch_int_ratio_o[8:0] == $past(wdata_i[11:4]) + 9'h001) else $error("ratio");
  a_frac_ch4: assert property (wr_en_i && addr_i == 5'h0b |=> ch_fraction_o[15:0] == $past(wdata_i)) else $error("ch4 fraction");
  a_frac_ch5: assert property (wr_en_i && addr_i == 5'h0e |=> ch_fraction_o[35:20] == $past(wdata_i)) else $error("ch5 fraction");
  a_read_pulse: assert property (1'b1 |=> rvalid_o == $past(rd_en_i)) else $error("read valid");
  c_frac_on: cover property (w4 && wdata_i[9]);
  c_ch5_write: cover property (w5);
  c_read: cover property (rd_en_i ##1 rvalid_o);
endmodule

// ===== verif/clock_output_channel_config_tb.sv
/* Self-checking bench for the channel 4/5 bank.
   Assumes host model and checker compiled first. */
`timescale 1ns/1ps
module clock_output_channel_config_tb;
  reg         clock_i;
  reg         rst_i;
  wire        wr_en_i, rd_en_i, rvalid_o;
  wire [1:0]  ch_fraction_en_o, ch_edge_slow_o, ch_pos_en_o, ch_neg_en_o, ch_supply_hi_o;
  wire [3:0]  ch_source_o, ch_prescale_o, ch_driver_o, ch_control_o;
  wire [4:0]  addr_i;
  wire [15:0] wdata_i, rdata_o;
  wire [17:0] ch_int_ratio_o;
  wire [39:0] ch_fraction_o;
  reg  [15:0] d;
  integer     n_errors = 0, n_compared = 0, i;
  clock_output_channel_config clock_output_channel_config_inst (.clock_i(clock_i), .rst_i(rst_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .ch_source_o(ch_source_o), .ch_prescale_o(ch_prescale_o),
    .ch_fraction_en_o(ch_fraction_en_o), .ch_edge_slow_o(ch_edge_slow_o), .ch_pos_en_o(ch_pos_en_o),
    .ch_neg_en_o(ch_neg_en_o), .ch_driver_o(ch_driver_o), .ch_control_o(ch_control_o),
    .ch_supply_hi_o(ch_supply_hi_o), .ch_int_ratio_o(ch_int_ratio_o), .ch_fraction_o(ch_fraction_o));
  cfg_host_model cfg_host_model_inst (.clock_i(clock_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
  // 50 ns clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // Compare and count
  task chk(input [39:0] got, input [39:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Both channels get one config word, prescale checked
  task pc(input [15:0] w, input [1:0] e);
    begin
      cfg_host_model_inst.wr(5'h09, w);
      cfg_host_model_inst.wr(5'h0c, w);
      chk(ch_prescale_o, {e, e});
      chk(ch_fraction_en_o, {2{w[9]}});
    end
  endtask
  // Reset state and the supply bit left low
  task t_reset;
    begin
      for (i = 9; i < 15; i = i + 1) begin
        cfg_host_model_inst.rd(i[4:0], d);
        chk(d, 40'h0);
      end
      chk({ch_source_o, ch_prescale_o, ch_int_ratio_o}, 40'h140201);
      chk(ch_supply_hi_o, 40'h0);
      $display("t_reset done");
    end
  endtask
  // Every source, driver and control code on both channels
  task t_codes;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        cfg_host_model_inst.wr(5'h09, {1'b0, i[1:0], 8'h00, i[1:0], i[1:0], 1'b0});
        cfg_host_model_inst.wr(5'h0c, {1'b0, ~i[1:0], 8'h00, i[1:0], ~i[1:0], 1'b0});
        chk(ch_source_o, (((8'h24 >> (6 - 2 * i)) & 8'h03) << 2) | ((8'h24 >> (2 * i)) & 8'h03));
        chk(ch_driver_o, (((8'h90 >> (2 * i)) & 8'h03) << 2) | ((8'h90 >> (2 * i)) & 8'h03));
        chk(ch_control_o, {~i[1:0], i[1:0]});
      end
      cfg_host_model_inst.wr(5'h09, 16'h0080);
      chk({ch_neg_en_o, ch_pos_en_o}, 40'h0);
      cfg_host_model_inst.wr(5'h09, 16'h01c1);
      cfg_host_model_inst.wr(5'h0c, 16'h0040);
      chk({ch_edge_slow_o, ch_pos_en_o, ch_neg_en_o, ch_supply_hi_o}, 40'h75);
      pc(16'h0000, 2'h1);
      pc(16'h0200, 2'h2);
      pc(16'h0600, 2'h3);
      pc(16'h1e00, 2'h1);
      pc(16'h0400, 2'h1);
      $display("t_codes done");
    end
  endtask
  // Dividers and fractions with a slow host, then readback
  task t_divider;
    begin
      cfg_host_model_inst.idle = 2;
      cfg_host_model_inst.wr(5'h0a, 16'h0fff);
      cfg_host_model_inst.wr(5'h0b, 16'h1234);
      cfg_host_model_inst.wr(5'h0d, 16'h0a50);
      cfg_host_model_inst.wr(5'h0e, 16'hfedc);
      chk(ch_int_ratio_o, {9'h0a6, 9'h100});
      chk(ch_fraction_o, {20'h0fedc, 20'hf1234});
      cfg_host_model_inst.rd(5'h0e, d);
      chk(d, 40'hfedc);
      cfg_host_model_inst.rd(5'h1f, d);
      chk(d, 40'h0);
      cfg_host_model_inst.idle = 0;
      $display("t_divider done");
    end
  endtask
  // Counts and verdict
  task summarize;
    begin
      $display("compared=%0d errors=%0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    rst_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1 rst_i = 1'b0;
    t_reset;
    t_codes;
    t_divider;
    summarize;
  end
  // Watchdog
  initial begin
    #100000;
    n_errors = n_errors + 1;
    summarize;
  end
endmodule
bind clock_output_channel_config clock_output_channel_config_chk chk_inst (.clock_i(clock_i), .rst_i(rst_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rvalid_o(rvalid_o), .addr_i(addr_i), .wdata_i(wdata_i),
  .ch_pos_en_o(ch_pos_en_o), .ch_neg_en_o(ch_neg_en_o), .ch_source_o(ch_source_o),
  .ch_prescale_o(ch_prescale_o), .ch_driver_o(ch_driver_o), .ch_control_o(ch_control_o),
  .ch_int_ratio_o(ch_int_ratio_o), .ch_fraction_o(ch_fraction_o));
